// File: pkg/ckgen_pkg.sv
// constants and types of the clock generator control block
package ckgen_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MAIN_OSC = 8'h00;
  localparam logic [7:0] OFS_MAIN_FREQ = 8'h04;
  localparam logic [7:0] OFS_PLL_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // main_osc_reg fields
  localparam int MOR_EN_BIT = 0;
  localparam int MOR_BYP_BIT = 1;
  localparam int MOR_CNT_LSB = 8;
  localparam int MOR_CNT_W = 8;
  // main_freq_reg fields
  localparam int MCF_TALLY_W = 16;
  localparam int MCF_DONE_BIT = 16;
  // pll_config_reg fields
  localparam int PLL_DIV_LSB = 0;
  localparam int PLL_DIV_W = 8;
  localparam int PLL_CNT_LSB = 8;
  localparam int PLL_CNT_W = 6;
  localparam int PLL_MUL_LSB = 16;
  localparam int PLL_MUL_W = 11;
  // status / mask bits
  localparam int ST_OSC_BIT = 0;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_W = 3;
  // timing
  localparam int OSC_TICK_DIV = 8;
  localparam int FREQ_PERIODS = 16;
  localparam logic [31:0] RST_VALUE = 32'h0000_0000;

  typedef struct packed {
    logic [PLL_MUL_W-1:0] mul;
    logic [PLL_CNT_W-1:0] cnt;
    logic [PLL_DIV_W-1:0] div;
  } ckgen_pll_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ckgen_apb_req_t;
endpackage

// File: design/ckgen_ctrl.sv
// clock generator control: oscillator startup, frequency meter, pll divider and lock timer
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ckgen_ctrl
  import ckgen_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SLOW_CLOCK_I,
  input wire logic MAIN_CLOCK_I,
  output logic MAIN_OSC_ENABLE_O,
  output logic EXT_CLOCK_SELECT_O,
  output logic [ckgen_pkg::PLL_DIV_W-1:0] PLL_PRESCALE_O,
  output logic [ckgen_pkg::PLL_MUL_W-1:0] PLL_FEEDBACK_O,
  output logic PLL_ENABLE_O,
  output logic PLL_SRC_GATE_O,
  output logic IRQ_O
);
  import ckgen_pkg::*;

  ckgen_apb_req_t req;
  logic wr_en, rd_en, addr_ok;
  // synchronisers: first stage read only by second
  logic [1:0] slow_sync_ff, main_sync_ff;
  logic slow_prev_ff, main_prev_ff;
  logic slow_rise, slow_fall, main_rise;
  // registers
  logic osc_en_ff, nxt_osc_en;
  logic byp_ff, nxt_byp;
  logic [MOR_CNT_W-1:0] osc_cnt_ff, nxt_osc_cnt;
  logic [2:0] div8_ff, nxt_div8;
  logic osc_busy_ff, nxt_osc_busy;
  ckgen_pll_cfg_t pll_ff, nxt_pll;
  logic [PLL_CNT_W-1:0] lock_cnt_ff, nxt_lock_cnt;
  logic lock_busy_ff, nxt_lock_busy;
  logic [ST_W-1:0] st_ff, nxt_st;
  logic [ST_W-1:0] mask_ff, nxt_mask;
  logic [MCF_TALLY_W-1:0] tally_ff, nxt_tally;
  logic done_ff, nxt_done;
  logic [4:0] fedge_ff, nxt_fedge;
  typedef enum {MS_IDLE, MS_ARM, MS_COUNT, MS_DONE} ckgen_meas_t;
  ckgen_meas_t meas_ff, nxt_meas;
  logic stable_prev_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  logic osc_set, lock_set;
  ckgen_pll_cfg_t wcfg;

  always_comb
  begin
    req.psel = PSEL_I;
    req.penable = PENABLE_I;
    req.pwrite = PWRITE_I;
    req.paddr = PADDR_I;
    req.pwdata = PWDATA_I;
  end

  assign addr_ok = (req.paddr == OFS_MAIN_OSC) || (req.paddr == OFS_MAIN_FREQ) ||
                   (req.paddr == OFS_PLL_CFG) || (req.paddr == OFS_STATUS) ||
                   (req.paddr == OFS_IRQ_MASK);
  assign wr_en = req.psel && req.penable && req.pwrite && addr_ok;
  assign rd_en = req.psel && !req.penable && !req.pwrite;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = req.psel && req.penable && !addr_ok;
  assign slow_rise = slow_sync_ff[1] && !slow_prev_ff;
  assign slow_fall = !slow_sync_ff[1] && slow_prev_ff;
  assign main_rise = main_sync_ff[1] && !main_prev_ff;
  assign wcfg = ckgen_pll_cfg_t'({req.pwdata[PLL_MUL_LSB +: PLL_MUL_W],
                                  req.pwdata[PLL_CNT_LSB +: PLL_CNT_W],
                                  req.pwdata[PLL_DIV_LSB +: PLL_DIV_W]});

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      slow_sync_ff <= 2'b00;
      main_sync_ff <= 2'b00;
      slow_prev_ff <= 1'b0;
      main_prev_ff <= 1'b0;
    end
    else
    begin
      slow_sync_ff <= {slow_sync_ff[0], SLOW_CLOCK_I};
      main_sync_ff <= {main_sync_ff[0], MAIN_CLOCK_I};
      slow_prev_ff <= slow_sync_ff[1];
      main_prev_ff <= main_sync_ff[1];
    end
  end

  // oscillator control and startup countdown
  always_comb
  begin
    nxt_osc_en = osc_en_ff;
    nxt_byp = byp_ff;
    nxt_osc_cnt = osc_cnt_ff;
    nxt_div8 = div8_ff;
    nxt_osc_busy = osc_busy_ff;
    osc_set = 1'b0;
    if (osc_busy_ff && slow_rise)
    begin
      if (osc_cnt_ff == '0)
      begin
        nxt_osc_busy = 1'b0;
        osc_set = 1'b1;
      end
      else if (div8_ff == 3'(OSC_TICK_DIV - 1))
      begin
        nxt_div8 = 3'h0;
        nxt_osc_cnt = osc_cnt_ff - 1'b1;
      end
      else
        nxt_div8 = div8_ff + 1'b1;
    end
    if (wr_en && req.paddr == OFS_MAIN_OSC)
    begin
      nxt_osc_en = req.pwdata[MOR_EN_BIT];
      nxt_byp = req.pwdata[MOR_BYP_BIT];
      nxt_osc_cnt = req.pwdata[MOR_CNT_LSB +: MOR_CNT_W];
      nxt_div8 = 3'h0;
      nxt_osc_busy = req.pwdata[MOR_EN_BIT];
      osc_set = 1'b0;
    end
  end

  // pll configuration and lock timer
  always_comb
  begin
    nxt_pll = pll_ff;
    nxt_lock_cnt = lock_cnt_ff;
    nxt_lock_busy = lock_busy_ff;
    lock_set = 1'b0;
    if (lock_busy_ff && slow_rise)
    begin
      if (lock_cnt_ff == '0)
      begin
        nxt_lock_busy = 1'b0;
        lock_set = 1'b1;
      end
      else
        nxt_lock_cnt = lock_cnt_ff - 1'b1;
    end
    if (wr_en && req.paddr == OFS_PLL_CFG)
    begin
      nxt_pll = wcfg;
      if (wcfg != pll_ff)
      begin
        nxt_lock_cnt = wcfg.cnt;
        nxt_lock_busy = (wcfg.mul != '0) && (wcfg.div != '0);
        lock_set = 1'b0;
      end
    end
  end

  // status, mask, sticky flags: hardware set wins over a status write-1 clear; a main oscillator or changed pll config write wins over hardware set
  always_comb
  begin
    nxt_st = st_ff;
    nxt_mask = mask_ff;
    if (wr_en && req.paddr == OFS_STATUS)
      nxt_st = st_ff & ~req.pwdata[ST_W-1:0];
    if (wr_en && req.paddr == OFS_IRQ_MASK)
      nxt_mask = req.pwdata[ST_W-1:0];
    if (wr_en && req.paddr == OFS_MAIN_OSC)
      nxt_st[ST_OSC_BIT] = 1'b0;
    if (wr_en && req.paddr == OFS_PLL_CFG && wcfg != pll_ff)
      nxt_st[ST_LOCK_BIT] = 1'b0;
    if (osc_set)
      nxt_st[ST_OSC_BIT] = 1'b1;
    if (lock_set)
      nxt_st[ST_LOCK_BIT] = 1'b1;
  end

  // main clock frequency measurement
  always_comb
  begin
    nxt_meas = meas_ff;
    nxt_tally = tally_ff;
    nxt_done = done_ff;
    nxt_fedge = fedge_ff;
    case (meas_ff)
      MS_IDLE:
      begin
        if (st_ff[ST_OSC_BIT] && !stable_prev_ff)
        begin
          nxt_done = 1'b0;
          nxt_tally = '0;
          nxt_meas = MS_ARM;
        end
      end
      MS_ARM:
      begin
        if (slow_rise)
        begin
          nxt_fedge = 5'h00;
          nxt_meas = MS_COUNT;
        end
      end
      MS_COUNT:
      begin
        if (main_rise)
          nxt_tally = tally_ff + 1'b1;
        if (slow_fall)
        begin
          nxt_fedge = fedge_ff + 1'b1;
          if (fedge_ff == 5'(FREQ_PERIODS - 1))
          begin
            nxt_done = 1'b1;
            nxt_meas = MS_DONE;
          end
        end
      end
      MS_DONE:
        nxt_meas = MS_IDLE;
      default:
        nxt_meas = MS_IDLE;
    endcase
    if (!st_ff[ST_OSC_BIT] && meas_ff != MS_DONE && meas_ff != MS_IDLE)
      nxt_meas = MS_IDLE;
  end

  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (rd_en)
    begin
      case (req.paddr)
        OFS_MAIN_OSC:
          nxt_rdata = {16'h0000, osc_cnt_ff, 6'h00, byp_ff, osc_en_ff};
        OFS_MAIN_FREQ:
          nxt_rdata = {15'h0000, done_ff, tally_ff};
        OFS_PLL_CFG:
          nxt_rdata = {5'h00, pll_ff.mul, 2'h0, pll_ff.cnt, pll_ff.div};
        OFS_STATUS:
          nxt_rdata = {29'h0, st_ff};
        OFS_IRQ_MASK:
          nxt_rdata = {29'h0, mask_ff};
        default:
          nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      osc_en_ff <= 1'b0;
      byp_ff <= 1'b0;
      osc_cnt_ff <= '0;
      div8_ff <= 3'h0;
      osc_busy_ff <= 1'b0;
      pll_ff <= ckgen_pll_cfg_t'(RST_VALUE[$bits(ckgen_pll_cfg_t)-1:0]);
      lock_cnt_ff <= '0;
      lock_busy_ff <= 1'b0;
      st_ff <= '0;
      mask_ff <= '0;
      tally_ff <= '0;
      done_ff <= 1'b0;
      fedge_ff <= 5'h00;
      meas_ff <= MS_IDLE;
      stable_prev_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      osc_en_ff <= nxt_osc_en;
      byp_ff <= nxt_byp;
      osc_cnt_ff <= nxt_osc_cnt;
      div8_ff <= nxt_div8;
      osc_busy_ff <= nxt_osc_busy;
      pll_ff <= nxt_pll;
      lock_cnt_ff <= nxt_lock_cnt;
      lock_busy_ff <= nxt_lock_busy;
      st_ff <= nxt_st;
      mask_ff <= nxt_mask;
      tally_ff <= nxt_tally;
      done_ff <= nxt_done;
      fedge_ff <= nxt_fedge;
      meas_ff <= nxt_meas;
      stable_prev_ff <= st_ff[ST_OSC_BIT];
      rdata_ff <= nxt_rdata;
    end
  end

  assign PRDATA_O = rdata_ff;
  assign MAIN_OSC_ENABLE_O = osc_en_ff;
  assign EXT_CLOCK_SELECT_O = byp_ff;
  // analog divider/pll take these factors: f = src*(feedback+1)/prescale
  assign PLL_PRESCALE_O = pll_ff.div;
  assign PLL_FEEDBACK_O = pll_ff.mul;
  assign PLL_ENABLE_O = (pll_ff.mul != '0) && (pll_ff.div != '0);
  assign PLL_SRC_GATE_O = (pll_ff.div != '0);
  assign IRQ_O = |(st_ff & mask_ff);
endmodule
`default_nettype wire

// File: sim/ckgen_ctrl_asserts.sv
// port assertions of the clock generator control block
`timescale 1ns/10ps
`default_nettype none
module ckgen_ctrl_asserts
  import ckgen_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic MAIN_OSC_ENABLE_O,
  input wire logic [ckgen_pkg::PLL_DIV_W-1:0] PLL_PRESCALE_O,
  input wire logic [ckgen_pkg::PLL_MUL_W-1:0] PLL_FEEDBACK_O,
  input wire logic PLL_ENABLE_O,
  input wire logic PLL_SRC_GATE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic [31:0] pw_ff;
  logic wr_osc;
  logic wr_pll;
  assign wr_osc = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == OFS_MAIN_OSC);
  assign wr_pll = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == OFS_PLL_CFG);
  always_ff @(posedge REF_CLK_I) pw_ff <= PWDATA_I;
  a_osc_off_rst: assert property ($rose(ARST_N_I) |-> !MAIN_OSC_ENABLE_O)
    else $error("oscillator enabled at reset release");
  a_osc_hold: assert property (!wr_osc |=> $stable(MAIN_OSC_ENABLE_O))
    else $error("oscillator enable moved without a write");
  a_osc_wr: assert property (wr_osc |=> MAIN_OSC_ENABLE_O == pw_ff[MOR_EN_BIT])
    else $error("oscillator enable does not follow the write");
  a_div_rst: assert property ($rose(ARST_N_I) |-> PLL_PRESCALE_O == 8'h00)
    else $error("prescale not zero at reset release");
  a_div_wr: assert property (wr_pll |=> PLL_PRESCALE_O == pw_ff[7:0])
    else $error("prescale does not follow the write");
  a_mul_wr: assert property (wr_pll |=> PLL_FEEDBACK_O == pw_ff[26:16])
    else $error("feedback does not follow the write");
  a_gate_div: assert property (PLL_SRC_GATE_O == (PLL_PRESCALE_O != 8'h00))
    else $error("source gate disagrees with prescale");
  a_pll_power: assert property (PLL_ENABLE_O ==
    (PLL_FEEDBACK_O != 11'h000 && PLL_PRESCALE_O != 8'h00))
    else $error("pll enable disagrees with factors");
endmodule
bind ckgen_ctrl ckgen_ctrl_asserts ckgen_ctrl_asserts_inst (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .MAIN_OSC_ENABLE_O(MAIN_OSC_ENABLE_O),
  .PLL_PRESCALE_O(PLL_PRESCALE_O), .PLL_FEEDBACK_O(PLL_FEEDBACK_O),
  .PLL_ENABLE_O(PLL_ENABLE_O), .PLL_SRC_GATE_O(PLL_SRC_GATE_O));
`default_nettype wire

// File: sim/ckgen_src_model.sv
// crystal or external source and permanent slow clock
`timescale 1ns/10ps
`default_nettype none
module ckgen_src_model #(
  parameter int SLOW_HALF = 200,
  parameter int MAIN_HALF = 50
) (
  input wire logic osc_en_i,
  input wire logic byp_i,
  output logic slow_o,
  output logic main_o
);
  initial
  begin
    slow_o = 1'b0;
    main_o = 1'b0;
  end
  always #SLOW_HALF slow_o = ~slow_o;
  // main clock stops low while the source is unpowered
  always #MAIN_HALF main_o = (osc_en_i | byp_i) ? ~main_o : 1'b0;
endmodule
`default_nettype wire

// File: sim/ckgen_ctrl_tb.sv
// self-checking bench of the clock generator control block
`timescale 1ns/10ps
`default_nettype none
module ckgen_ctrl_tb;
  import ckgen_pkg::*;
  localparam int SH = 200;
  localparam int MH = 50;
  localparam int SP = 2 * SH / 20;
  logic clk, rst_n, psel, penable, pwrite, pready, slv, err_q, irq;
  logic mosc, byp, gate, pen, slow, main;
  logic [7:0] paddr, div, cnt;
  logic [10:0] fb;
  logic [31:0] pwdata, prdata, q, seed;
  ckgen_pll_cfg_t pc;
  int errors, n_tests, cyc, t0, d, k;
  ckgen_ctrl ckgen_ctrl_inst (.REF_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slv), .SLOW_CLOCK_I(slow),
    .MAIN_CLOCK_I(main), .MAIN_OSC_ENABLE_O(mosc), .EXT_CLOCK_SELECT_O(byp),
    .PLL_PRESCALE_O(div), .PLL_FEEDBACK_O(fb), .PLL_ENABLE_O(pen),
    .PLL_SRC_GATE_O(gate), .IRQ_O(irq));
  ckgen_src_model #(.SLOW_HALF(SH), .MAIN_HALF(MH)) ckgen_src_model_inst (
    .osc_en_i(mosc), .byp_i(byp), .slow_o(slow), .main_o(main));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int exp_tally();
    return 16 * SH / MH;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err_q = slv;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wait_win(input int lo, input int hi);
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
    d = cyc - t0;
    chk(32'(d >= lo && d <= hi), 32'h1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial
  begin
    seed = 32'h0000_b484;
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {errors, n_tests, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_MAIN_OSC, 32'h0);
    chk(q | 32'(mosc), RST_VALUE);
    apb(1'b0, OFS_PLL_CFG, 32'h0);
    chk(q | 32'(gate), RST_VALUE);
    apb(1'b0, 8'h14, 32'h0);
    chk({q[30:0], err_q}, 32'h1);
    $display("test reset done");
    apb(1'b1, OFS_IRQ_MASK, 32'h5);
    for (int i = 0; i < 3; i++)
    begin
      cnt = 8'(rnd() % 3 + 1);
      t0 = cyc;
      apb(1'b1, OFS_MAIN_OSC, {16'h0000, cnt, 8'h01});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[ST_OSC_BIT]), 32'h0);
      wait_win(8 * cnt * SP, (8 * cnt + 3) * SP);
      apb(1'b0, OFS_MAIN_FREQ, 32'h0);
      chk(32'(q[MCF_DONE_BIT]), 32'h0);
      for (k = 0; k < 80 && q[MCF_DONE_BIT] !== 1'b1; k++)
      begin
        repeat (8) @(posedge clk);
        apb(1'b0, OFS_MAIN_FREQ, 32'h0);
      end
      d = int'(q[15:0]) - exp_tally();
      chk({q[MCF_DONE_BIT], 31'(d >= -2 && d <= 2)}, 32'h8000_0001);
      apb(1'b1, (i == 1) ? OFS_STATUS : OFS_IRQ_MASK, (i == 1) ? 32'h1 : 32'h0);
      chk(32'(irq), 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h5);
      chk(32'(irq), (i == 1) ? 32'h0 : 32'h1);
      $display("test oscillator %0d done", i);
    end
    apb(1'b1, OFS_MAIN_OSC, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({q[ST_OSC_BIT], mosc, irq}, 3'h0);
    apb(1'b1, OFS_MAIN_OSC, 32'h2);
    chk({byp, mosc}, 2'h2);
    for (int i = 0; i < 3; i++)
    begin
      pc.div = 8'(rnd() % 255 + 1);
      pc.mul = 11'(rnd() % 2047 + 1);
      pc.cnt = 6'(rnd() % 8 + 1);
      t0 = cyc;
      apb(1'b1, OFS_PLL_CFG, {5'h00, pc.mul, 2'h0, pc.cnt, pc.div});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[ST_LOCK_BIT]), 32'h0);
      wait_win(pc.cnt * SP, (pc.cnt + 3) * SP);
      chk({12'h0, pen, fb, div}, {12'h1, pc.mul, pc.div});
      // leave settled set so the next reprogramming has to clear it
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[ST_LOCK_BIT]), 32'h1);
      $display("test pll %0d done", i);
    end
    apb(1'b1, OFS_PLL_CFG, 32'h0005_0000);
    chk({gate, pen}, 2'h0);
    apb(1'b1, OFS_PLL_CFG, 32'h0000_0005);
    chk({gate, pen}, 2'h2);
    $display("test pll gating done");
    end_of_test();
  end
endmodule
`default_nettype wire
